// ### verilog/dux_pkg.sv
// Shared constants for the dual serial port: register map, field
// positions, reset values, modes, state codes and divider ratios.
// Assumes a byte-addressed 32-bit classic Wishbone register bus.
package dux_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int NPORT = 2;
  localparam int ADR_W = 8;
  localparam logic [7:0] PORT_STRIDE = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_CLKSEL = 8'h20;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTRL_MODE_HI = 7;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_RXEN = 4;
  localparam int CTRL_TXNINTH = 3;
  localparam int CTRL_RXNINTH = 2;
  localparam int CTRL_TXDONE = 1;
  localparam int CTRL_RXDONE = 0;
  localparam int STAT_FE = 3;
  localparam int STAT_BR = 2;
  localparam int STAT_OE = 1;
  localparam int STAT_STINT = 0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [3:0] CLKSEL_RST = 4'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  // Sixteen samples per bit; the shift mode also uses it as clk/16
  localparam int OVS_DIV = 16;
  // Fixed 9-bit mode: clk/2 sample rate gives clk/32 bits
  localparam int MODE2_PRE_DIV = 2;
  localparam logic [3:0] IDX_LAST_SHIFT = 4'h7;
  localparam logic [3:0] IDX_LAST_8BIT = 4'h9;
  localparam logic [3:0] IDX_NINTH = 4'h9;
  localparam logic [3:0] IDX_LAST_9BIT = 4'hA;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'h0,
    MODE_8BIT = 2'h1,
    MODE_9FIX = 2'h2,
    MODE_9VAR = 2'h3
  } dux_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_SEND = 2'h1
  } dux_tx_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'h0,
    RX_START = 2'h1,
    RX_DATA = 2'h3
  } dux_rx_t;

endpackage : dux_pkg

// ### verilog/dux_tick_div.sv
// Tick divider: counts input ticks, pulses at the wrap and at mid count.
// Assumes tickIn and clr are on clk_sys; clr restarts the count.
`timescale 1ns/100ps
module dux_tick_div #(
  parameter int DIV = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clr,
  input wire logic tickIn,
  output logic tickOut,
  output logic midOut,
  output logic phaseHigh
);

  localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt_reg;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (clr)
      cnt_reg <= '0;
    else if (tickIn)
    begin
      if (cnt_reg == CW'(DIV - 1))
        cnt_reg <= '0;
      else
        cnt_reg <= cnt_reg + CW'(1);
    end
  end

  assign tickOut = tickIn & (cnt_reg == CW'(DIV - 1));
  assign midOut = tickIn & (cnt_reg == CW'(DIV / 2 - 1));
  assign phaseHigh = (cnt_reg >= CW'(DIV / 2));

endmodule : dux_tick_div

// ### verilog/dux_dual_uart.sv
// Two serial ports behind a classic Wishbone slave, with shift mode and
// 8/9-bit framed modes, double buffered transmit and receive error flags.
// Assumes timer1Ovf/timer2Ovf are one-cycle pulses on clk_sys.
`timescale 1ns/100ps
module dux_dual_uart (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic timer1Ovf,
  input wire logic timer2Ovf,
  input wire logic [1:0] serialInPin,
  output logic [1:0] serialInPinOut,
  output logic [1:0] serialInPinOe,
  output logic [1:0] serialOutPin,
  output logic [1:0] txIrq,
  output logic [1:0] rxIrq
);

  localparam int NP = dux_pkg::NPORT;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic busReq;
  logic busWr;
  logic [NP-1:0] wrData;
  logic [NP-1:0] wrCtrl;
  logic [NP-1:0] wrStat;
  logic wrClk;
  logic [7:0] rdByte;
  logic [7:0] wrByte;
  logic [NP-1:0][7:0] rxView;
  logic [NP-1:0][7:0] ctrlView;
  logic [NP-1:0][7:0] statView;
  logic [3:0] clkSel_reg;

  assign busReq = cyc_i & stb_i & ~ack_o;
  assign busWr = busReq & we_i & sel_i[0];
  assign wrByte = dat_i[7:0];

  always_comb
  begin
    logic [7:0] base;
    base = 8'h00;
    rdByte = 8'h00;
    wrData = '0;
    wrCtrl = '0;
    wrStat = '0;
    wrClk = 1'b0;
    if (adr_i == dux_pkg::OFS_CLKSEL)
    begin
      rdByte = {4'h0, clkSel_reg};
      wrClk = busWr;
    end
    for (int n = 0; n < NP; n++)
    begin
      base = 8'(n) * dux_pkg::PORT_STRIDE;
      if (adr_i == base + dux_pkg::OFS_DATA)
      begin
        rdByte = rxView[n];
        wrData[n] = busWr;
      end
      else if (adr_i == base + dux_pkg::OFS_CTRL)
      begin
        rdByte = ctrlView[n];
        wrCtrl[n] = busWr;
      end
      else if (adr_i == base + dux_pkg::OFS_STAT)
      begin
        rdByte = statView[n];
        wrStat[n] = busWr;
      end
    end
  end

  // Single wait state; unmapped addresses are acked and read zero
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= busReq;
      dat_o <= (busReq & ~we_i) ? {24'h00_0000, rdByte} : 32'h0000_0000;
    end
  end

  // Cleared at reset, so timer 1 clocks both ports
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      clkSel_reg <= dux_pkg::CLKSEL_RST;
    else if (wrClk)
      clkSel_reg <= wrByte[3:0];
  end

  // ----------------------------------------
  // Fixed prescaler
  // ----------------------------------------
  logic div2Tick;

  dux_tick_div #(
    .DIV(dux_pkg::MODE2_PRE_DIV)
  ) u_pre (
    .clk_sys(clk_sys),
    .rst(rst),
    .clr(1'b0),
    .tickIn(1'b1),
    .tickOut(div2Tick),
    .midOut(),
    .phaseHigh()
  );

  // ----------------------------------------
  // Serial ports
  // ----------------------------------------
  for (genvar n = 0; n < NP; n++)
  begin : g_port
    dux_pkg::dux_mode_t mode_reg;
    dux_pkg::dux_tx_t txState;
    dux_pkg::dux_rx_t rxState;
    logic rxEn_reg, txNinth_reg, rxNinth_reg, txDone_reg, rxDone_reg;
    logic fe_reg, br_reg, oe_reg, stint_reg;
    logic [7:0] txData_reg, txBuf_reg, rxShift_reg, rxBuf_reg;
    logic txBufFull_reg;
    logic [3:0] txIdx_reg, rxIdx_reg;
    logic rxNin_reg, rxAllZero_reg;
    logic inSync1_reg, inSync2_reg, inPrev_reg;
    logic outPin_reg, dataOut_reg, dataOe_reg, txIrq_reg, rxIrq_reg;
    logic isShift, ovsTx, ovsRx, txTickIn, rxTickIn;
    logic txBitEnd, txPhase, txClr, rxTick, rxMid, rxPhase, rxClr;
    logic [3:0] txLast, rxLast;
    logic txBit, txEnd, txDoneSet, rxSmp, rxFinish, rxStartFramed;
    logic rxStartShift, feSet, brSet, oeSet;

    assign isShift = (mode_reg == dux_pkg::MODE_SHIFT);
    // Fixed rates in modes 0 and 2, timer ticks in modes 1 and 3
    assign ovsTx = (mode_reg == dux_pkg::MODE_9FIX) ? div2Tick :
                   (clkSel_reg[2*n+1] ? timer2Ovf : timer1Ovf);
    assign ovsRx = (mode_reg == dux_pkg::MODE_9FIX) ? div2Tick :
                   (clkSel_reg[2*n] ? timer2Ovf : timer1Ovf);
    assign txTickIn = isShift ? 1'b1 : ovsTx;
    assign rxTickIn = isShift ? 1'b1 : ovsRx;
    assign txLast = isShift ? dux_pkg::IDX_LAST_SHIFT :
                    (mode_reg == dux_pkg::MODE_8BIT) ? dux_pkg::IDX_LAST_8BIT :
                    dux_pkg::IDX_LAST_9BIT;
    assign rxLast = txLast;

    dux_tick_div #(
      .DIV(dux_pkg::OVS_DIV)
    ) u_txdiv (
      .clk_sys(clk_sys),
      .rst(rst),
      .clr(txClr),
      .tickIn(txTickIn),
      .tickOut(txBitEnd),
      .midOut(),
      .phaseHigh(txPhase)
    );

    dux_tick_div #(
      .DIV(dux_pkg::OVS_DIV)
    ) u_rxdiv (
      .clk_sys(clk_sys),
      .rst(rst),
      .clr(rxClr),
      .tickIn(rxTickIn),
      .tickOut(rxTick),
      .midOut(rxMid),
      .phaseHigh(rxPhase)
    );

    // ----------------------------------------
    // Control and status registers
    // ----------------------------------------
    assign ctrlView[n] = {mode_reg, 1'b0, rxEn_reg, txNinth_reg, rxNinth_reg,
                          txDone_reg, rxDone_reg};
    assign statView[n] = {4'h0, fe_reg, br_reg, oe_reg, stint_reg};
    assign rxView[n] = rxBuf_reg;

    // Hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst)
      begin
        mode_reg <= dux_pkg::MODE_SHIFT;
        rxEn_reg <= dux_pkg::CTRL_RST[dux_pkg::CTRL_RXEN];
        txNinth_reg <= dux_pkg::CTRL_RST[dux_pkg::CTRL_TXNINTH];
        txDone_reg <= dux_pkg::CTRL_RST[dux_pkg::CTRL_TXDONE];
      end
      else
      begin
        if (wrCtrl[n])
        begin
          mode_reg <= dux_pkg::dux_mode_t'(wrByte[dux_pkg::CTRL_MODE_HI:dux_pkg::CTRL_MODE_LO]);
          rxEn_reg <= wrByte[dux_pkg::CTRL_RXEN];
          txNinth_reg <= wrByte[dux_pkg::CTRL_TXNINTH];
        end
        txDone_reg <= txDoneSet |
                      (wrCtrl[n] ? wrByte[dux_pkg::CTRL_TXDONE] : txDone_reg);
      end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst)
      begin
        fe_reg <= dux_pkg::STAT_RST[dux_pkg::STAT_FE];
        br_reg <= dux_pkg::STAT_RST[dux_pkg::STAT_BR];
        oe_reg <= dux_pkg::STAT_RST[dux_pkg::STAT_OE];
        stint_reg <= dux_pkg::STAT_RST[dux_pkg::STAT_STINT];
      end
      else
      begin
        fe_reg <= feSet | (wrStat[n] ? wrByte[dux_pkg::STAT_FE] : fe_reg);
        br_reg <= brSet | (wrStat[n] ? wrByte[dux_pkg::STAT_BR] : br_reg);
        oe_reg <= oeSet | (wrStat[n] ? wrByte[dux_pkg::STAT_OE] : oe_reg);
        if (wrStat[n])
          stint_reg <= wrByte[dux_pkg::STAT_STINT];
      end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    assign txEnd = (txState == dux_pkg::TX_SEND) & txBitEnd & (txIdx_reg == txLast);
    assign txClr = (txState == dux_pkg::TX_IDLE) & wrData[n];
    // Idle write flags the free queue slot; every byte end flags too
    assign txDoneSet = txEnd | txClr;

    // Ninth bit is read live, not copied at load time
    always_comb
    begin
      txBit = 1'b1;
      if (isShift)
        txBit = txData_reg[txIdx_reg[2:0]];
      else if (txIdx_reg == 4'h0)
        txBit = 1'b0;
      else if (txIdx_reg <= 4'h8)
        txBit = txData_reg[3'(txIdx_reg - 4'h1)];
      else if (txIdx_reg == dux_pkg::IDX_NINTH && mode_reg != dux_pkg::MODE_8BIT)
        txBit = txNinth_reg;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst)
      begin
        txState <= dux_pkg::TX_IDLE;
        txData_reg <= 8'h00;
        txBuf_reg <= 8'h00;
        txBufFull_reg <= 1'b0;
        txIdx_reg <= 4'h0;
      end
      else
      begin
        case (txState)
          dux_pkg::TX_IDLE:
          begin
            if (wrData[n])
            begin
              txData_reg <= wrByte;
              txIdx_reg <= 4'h0;
              txState <= dux_pkg::TX_SEND;
            end
          end
          dux_pkg::TX_SEND:
          begin
            if (txEnd)
            begin
              if (txBufFull_reg)
              begin
                txData_reg <= txBuf_reg;
                txIdx_reg <= 4'h0;
                txBufFull_reg <= wrData[n];
                if (wrData[n])
                  txBuf_reg <= wrByte;
              end
              else if (wrData[n])
              begin
                txData_reg <= wrByte;
                txIdx_reg <= 4'h0;
              end
              else
                txState <= dux_pkg::TX_IDLE;
            end
            else
            begin
              if (txBitEnd)
                txIdx_reg <= txIdx_reg + 4'h1;
              if (wrData[n])
              begin
                txBuf_reg <= wrByte;
                txBufFull_reg <= 1'b1;
              end
            end
          end
          default:
            txState <= dux_pkg::TX_IDLE;
        endcase
      end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst)
      begin
        inSync1_reg <= 1'b1;
        inSync2_reg <= 1'b1;
        inPrev_reg <= 1'b1;
      end
      else
      begin
        inSync1_reg <= serialInPin[n];
        inSync2_reg <= inSync1_reg;
        inPrev_reg <= inSync2_reg;
      end
    end

    assign rxStartFramed = ~isShift & rxEn_reg & (rxState == dux_pkg::RX_IDLE) &
                           inPrev_reg & ~inSync2_reg;
    // Shift receive waits for the shared clock pin to be free
    assign rxStartShift = isShift & rxEn_reg & ~rxDone_reg &
                          (rxState == dux_pkg::RX_IDLE) &
                          (txState == dux_pkg::TX_IDLE) & ~wrData[n];
    assign rxClr = rxStartFramed | rxStartShift;
    assign rxSmp = isShift ? rxTick : rxMid;
    assign rxFinish = (rxState == dux_pkg::RX_DATA) & rxSmp & (rxIdx_reg == rxLast);
    assign feSet = rxFinish & ~isShift & ~inSync2_reg;
    assign brSet = rxFinish & ~isShift & rxAllZero_reg & ~inSync2_reg;
    assign oeSet = rxFinish & rxDone_reg;

    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst)
      begin
        rxState <= dux_pkg::RX_IDLE;
        rxIdx_reg <= 4'h0;
        rxShift_reg <= 8'h00;
        rxNin_reg <= 1'b0;
        rxAllZero_reg <= 1'b0;
      end
      else
      begin
        case (rxState)
          dux_pkg::RX_IDLE:
          begin
            if (rxStartFramed)
              rxState <= dux_pkg::RX_START;
            else if (rxStartShift)
            begin
              rxIdx_reg <= 4'h0;
              rxState <= dux_pkg::RX_DATA;
            end
          end
          dux_pkg::RX_START:
          begin
            // A start bit gone high by mid bit was a glitch
            if (rxMid)
            begin
              rxState <= inSync2_reg ? dux_pkg::RX_IDLE : dux_pkg::RX_DATA;
              rxIdx_reg <= 4'h1;
              rxAllZero_reg <= 1'b1;
            end
          end
          dux_pkg::RX_DATA:
          begin
            if (rxSmp)
            begin
              rxAllZero_reg <= rxAllZero_reg & ~inSync2_reg;
              if (isShift || rxIdx_reg <= 4'h8)
                rxShift_reg <= {inSync2_reg, rxShift_reg[7:1]};
              if (rxIdx_reg == dux_pkg::IDX_NINTH)
                rxNin_reg <= inSync2_reg;
              rxIdx_reg <= rxIdx_reg + 4'h1;
              if (rxFinish)
                rxState <= dux_pkg::RX_IDLE;
            end
          end
          default:
            rxState <= dux_pkg::RX_IDLE;
        endcase
      end
    end

    // Overrun keeps the unread character; the new one is dropped
    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst)
      begin
        rxBuf_reg <= 8'h00;
        rxNinth_reg <= dux_pkg::CTRL_RST[dux_pkg::CTRL_RXNINTH];
        rxDone_reg <= dux_pkg::CTRL_RST[dux_pkg::CTRL_RXDONE];
      end
      else
      begin
        if (rxFinish && !rxDone_reg)
        begin
          rxBuf_reg <= isShift ? {inSync2_reg, rxShift_reg[7:1]} : rxShift_reg;
          // Mode 1 keeps the stop bit; modes 2 and 3 keep the ninth bit
          if (!isShift)
            rxNinth_reg <= (mode_reg == dux_pkg::MODE_8BIT) ? inSync2_reg
                                                             : rxNin_reg;
        end
        else if (wrCtrl[n])
          rxNinth_reg <= wrByte[dux_pkg::CTRL_RXNINTH];
        rxDone_reg <= rxFinish |
                      (wrCtrl[n] ? wrByte[dux_pkg::CTRL_RXDONE] : rxDone_reg);
      end
    end

    // ----------------------------------------
    // Pins and requests
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
      if (rst)
      begin
        outPin_reg <= 1'b1;
        dataOut_reg <= 1'b1;
        dataOe_reg <= 1'b0;
        txIrq_reg <= 1'b0;
        rxIrq_reg <= 1'b0;
      end
      else
      begin
        if (isShift)
          outPin_reg <= (txState == dux_pkg::TX_SEND) ? txPhase :
                        (rxState == dux_pkg::RX_DATA) ? rxPhase : 1'b1;
        else
          outPin_reg <= (txState == dux_pkg::TX_SEND) ? txBit : 1'b1;
        dataOut_reg <= txBit;
        dataOe_reg <= isShift & (txState == dux_pkg::TX_SEND);
        txIrq_reg <= txDone_reg;
        rxIrq_reg <= rxDone_reg | (stint_reg & (fe_reg | br_reg | oe_reg));
      end
    end

    assign serialOutPin[n] = outPin_reg;
    assign serialInPinOut[n] = dataOut_reg;
    assign serialInPinOe[n] = dataOe_reg;
    assign txIrq[n] = txIrq_reg;
    assign rxIrq[n] = rxIrq_reg;
  end

endmodule : dux_dual_uart

// ### verification/dux_uart_props.sv
// Checker for the dual serial port: bus handshake, pin timing, irqs.
// Assumes a bind to dux_dual_uart; sees only its top ports.
`timescale 1ns/100ps
module dux_uart_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [1:0] serialOutPin,
  input wire logic [1:0] txIrq,
  input wire logic [1:0] rxIrq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ----
  // Bus steps
  // ----
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_wr(logic [7:0] ofs, int b);
    s_take ##0 (we_i && sel_i[0] && adr_i == ofs && dat_i[b]);
  endsequence

  a_ack_pulse: assert property (s_take |=> ack_o ##1 !ack_o)
    else $error("ack is not one cycle after the request");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i) && $past(stb_i) && !$past(ack_o))
    else $error("ack without a request");
  a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside the ack cycle");
  a_dat_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data upper lanes not zero");
  // Shift clock halves are 8 clocks, framed bits longer
  a_bit_hold: assert property ($changed(serialOutPin[0]) |=> $stable(serialOutPin[0]) [*7])
    else $error("serial out level too short");
  a_txirq_set: assert property (s_wr(dux_pkg::OFS_CTRL, dux_pkg::CTRL_TXDONE) |-> ##2 txIrq[0])
    else $error("tx irq missing after done write");
  a_rxirq_done: assert property (s_wr(dux_pkg::OFS_CTRL, dux_pkg::CTRL_RXDONE) |-> ##2 rxIrq[0])
    else $error("rx irq missing after done write");
  a_rxirq_stat: assert property (s_wr(dux_pkg::OFS_STAT, dux_pkg::STAT_STINT) ##0 (dat_i[3:1] != 3'h0)
    |-> ##2 rxIrq[0])
    else $error("rx irq missing for enabled status flag");
endmodule : dux_uart_props

bind dux_dual_uart dux_uart_props dux_uart_props_inst (
  .clk_sys(clk_sys),
  .rst(rst),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .we_i(we_i),
  .adr_i(adr_i),
  .sel_i(sel_i),
  .dat_i(dat_i),
  .dat_o(dat_o),
  .ack_o(ack_o),
  .serialOutPin(serialOutPin),
  .txIrq(txIrq),
  .rxIrq(rxIrq)
);

// ### verification/dux_remote_model.sv
// Remote framed sender driving one receive pin of the serial port.
// Assumes bit times counted in clk_sys cycles; line idles high.
`timescale 1ns/100ps
module dux_remote_model #(
  parameter int BIT_CLK = 32
) (
  input wire logic clk_sys,
  output logic line
);
  // Pulled-up line, high between frames
  initial line = 1'b1;

  // Bits go out index 0 first: start, data LSB first, stop
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_sys);
      line <= bits[i];
      repeat (BIT_CLK - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    line <= 1'b1;
  endtask : send
endmodule : dux_remote_model

// ### verification/tb.sv
// Bench for the dual serial port: register rows, packed transmit on
// port 0, receive with errors, timer 2 and shift mode on port 1.
// Timer 1 ticks every 2 clocks, timer 2 every 4.
`timescale 1ns/100ps
module tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic timer1Ovf = 1'b0;
  logic [1:0] t2Cnt = 2'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [1:0] pinIn, pinOut, pinOe, serialOutPin, txIrq, rxIrq;
  logic remoteLine;
  logic [31:0] rd;
  logic [21:0] txBits;
  integer nErrors = 0;
  integer checkCount = 0;
  logic [23:0] rows [9] = '{24'h30FF00, 24'h041313, 24'h040000, 24'h080F0F,
    24'h080000, 24'h200F0F, 24'h200000, 24'h180101, 24'h180000};
  logic [7:0] zeroAdr [5] = '{8'h04, 8'h08, 8'h14, 8'h18, 8'h20};

  // Released pin 0 is pulled high; released pin 1 follows the remote line
  assign pinIn = {pinOe[1] ? pinOut[1] : remoteLine, pinOe[0] ? pinOut[0] : 1'b1};

  dux_dual_uart dux_dual_uart_inst (
    .clk_sys(clk_sys),
    .rst(rst),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .timer1Ovf(timer1Ovf),
    .timer2Ovf(t2Cnt == 2'h3),
    .serialInPin(pinIn),
    .serialInPinOut(pinOut),
    .serialInPinOe(pinOe),
    .serialOutPin(serialOutPin),
    .txIrq(txIrq),
    .rxIrq(rxIrq)
  );

  dux_remote_model #(.BIT_CLK(32)) dux_remote_model_inst (
    .clk_sys(clk_sys),
    .line(remoteLine)
  );

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) timer1Ovf <= ~timer1Ovf;
  always @(posedge clk_sys) t2Cnt <= t2Cnt + 2'h1;

  // ----
  // Helpers
  // ----
  function automatic logic [10:0] frame9(input logic [7:0] d, input logic n);
    frame9 = {1'b1, n, d, 1'b0};
  endfunction : frame9

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      nErrors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= {24'h0, d};
    do
      @(posedge clk_sys);
    while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : bus

  task automatic tally_and_finish;
    if (nErrors == 0 && checkCount > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    nErrors++;
    tally_and_finish;
  end

  // ----
  // Sequence
  // ----
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      bus(1'b1, rows[i][23:16], rows[i][15:8]);
      bus(1'b0, rows[i][23:16], 8'h00);
      chk("register row", rd, {24'h0, rows[i][7:0]});
    end
    bus(1'b1, 8'h04, 8'h13);
    rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    chk("irq after reset", {28'h0, txIrq, rxIrq}, 32'h0);
    foreach (zeroAdr[i])
    begin
      bus(1'b0, zeroAdr[i], 8'h00);
      chk("reset value", rd, 32'h0);
    end
    bus(1'b1, 8'h04, 8'h88);
    fork
      begin
        @(negedge serialOutPin[0]);
        for (int b = 0; b < 22; b++)
        begin
          repeat (16) @(posedge clk_sys);
          txBits[b] = serialOutPin[0];
          repeat (16) @(posedge clk_sys);
        end
      end
      begin
        bus(1'b1, 8'h00, 8'hA5);
        bus(1'b0, 8'h04, 8'h00);
        chk("done on idle load", rd, 32'h8A);
        // One byte per done flag keeps the queue at most one deep
        bus(1'b1, 8'h00, 8'h3C);
        // Ninth bit of the queued byte is read live, so change it now
        repeat (400) @(posedge clk_sys);
        bus(1'b1, 8'h04, 8'h80);
      end
    join
    chk("packed frames", {10'h0, txBits}, {10'h0, frame9(8'h3C, 1'b0), frame9(8'hA5, 1'b1)});
    repeat (4) @(posedge clk_sys);
    bus(1'b0, 8'h04, 8'h00);
    chk("done after last byte", rd, 32'h82);
    chk("tx irq", {31'h0, txIrq[0]}, 32'h1);
    bus(1'b1, 8'h14, 8'h40);
    dux_remote_model_inst.send({2'b11, 8'h5A, 1'b0}, 10);
    repeat (4) @(posedge clk_sys);
    bus(1'b0, 8'h14, 8'h00);
    chk("receiver off", rd, 32'h40);
    bus(1'b1, 8'h14, 8'h50);
    dux_remote_model_inst.send({2'b11, 8'h5A, 1'b0}, 10);
    repeat (4) @(posedge clk_sys);
    chk("rx irq", {31'h0, rxIrq[1]}, 32'h1);
    bus(1'b0, 8'h10, 8'h00);
    chk("rx byte", rd, 32'h5A);
    bus(1'b0, 8'h14, 8'h00);
    chk("rx stop to ninth", rd, 32'h55);
    dux_remote_model_inst.send({2'b11, 8'hC3, 1'b0}, 10);
    repeat (4) @(posedge clk_sys);
    bus(1'b0, 8'h18, 8'h00);
    chk("overrun", rd, 32'h02);
    bus(1'b0, 8'h10, 8'h00);
    chk("old byte kept", rd, 32'h5A);
    dux_remote_model_inst.send(11'h000, 10);
    repeat (4) @(posedge clk_sys);
    bus(1'b0, 8'h18, 8'h00);
    chk("break and framing", rd, 32'h0E);
    // Port 1 transmit on timer 2 in mode 3: 64-clock bits
    bus(1'b1, 8'h20, 8'h08);
    bus(1'b1, 8'h14, 8'hC8);
    bus(1'b1, 8'h10, 8'h6B);
    @(negedge serialOutPin[1]);
    repeat (32) @(posedge clk_sys);
    for (int b = 0; b < 11; b++)
    begin
      txBits[b] = serialOutPin[1];
      repeat (64) @(posedge clk_sys);
    end
    chk("timer 2 frame", {21'h0, txBits[10:0]}, {21'h0, frame9(8'h6B, 1'b1)});
    // Shift mode on port 1: data on the in-pin, clock on the out-pin
    bus(1'b1, 8'h14, 8'h00);
    bus(1'b1, 8'h10, 8'h96);
    bus(1'b1, 8'h14, 8'h00);
    for (int b = 0; b < 8; b++)
    begin
      @(posedge serialOutPin[1]);
      txBits[b] = pinOut[1];
      txBits[b + 8] = pinOe[1];
    end
    chk("shift data and enable", {16'h0, txBits[15:0]}, 32'h0000_FF96);
    repeat (16) @(posedge clk_sys);
    bus(1'b0, 8'h14, 8'h00);
    chk("shift done", rd, 32'h02);
    bus(1'b1, 8'h14, 8'h10);
    repeat (140) @(posedge clk_sys);
    bus(1'b0, 8'h14, 8'h00);
    chk("shift receive", rd, 32'h11);
    bus(1'b0, 8'h10, 8'h00);
    chk("shift byte", rd, 32'hFF);
    tally_and_finish;
  end
endmodule : tb
